// ---- src/rps_power_seq.sv ----
// Power sequencer: toggle qualification, hibernate control, serial pin gating,
// timing pulse generation and boot strap capture.
// Assumes all inputs are synchronous to ref_clk and the host keeps its own rules.
`timescale 1ns/100ps
module rps_power_seq
   import rps_pkg::*;
(
   input  wire logic ref_clk,              // System clock, 100 MHz.
   input  wire logic rst_n,                // Synchronous reset, active low.
   input  wire logic supplies_lost,        // High when main and backup both fell away.
   input  wire logic toggle_in,            // Power toggle input from the host.
   input  wire logic boot_select,          // Boot strap, low for normal operation.
   input  wire logic fix_3d_valid,         // Navigation core reports a valid 3D fix.
   input  wire logic utc_epoch,            // One-cycle pulse at each UTC second.
   input  wire logic primary_tx_data,      // Serial data from the primary transmitter.
   input  wire logic secondary_tx_data,    // Serial data from the secondary transmitter.
   input  wire logic secondary_enable,     // Secondary port enabled by configuration.
   input  wire logic primary_serial_in,    // Primary serial input from the host.
   input  wire logic secondary_serial_in,  // Secondary serial input from the host.
   input  wire logic fmt_cmd_valid,        // Serial port configuration command strobe.
   input  wire logic fmt_cmd_binary,       // Requested format, high for binary.
   output logic      io_rail_out,          // High while on, low in hibernate.
   output logic      core_power_en,        // Enable for switched internal supplies.
   output logic      primary_serial_out,   // Primary serial output pin.
   output logic      secondary_serial_out, // Secondary serial output pin.
   output logic      primary_rx_data,      // Primary input passed to the receiver.
   output logic      secondary_rx_data,    // Secondary input passed to the receiver.
   output logic      second_timing_pulse,  // Once-per-second timing pulse.
   output logic      factory_start,        // Factory start requested at power-up.
   output logic      boot_mode,            // Boot mode latched from the strap.
   output logic      format_binary         // Primary format, low for NMEA.
);

   // Power state and the toggle qualifier.
   rps_state_e  state_r, state_nxt;
   logic [16:0] tog_cnt_r, tog_cnt_nxt;   // Cycles the toggle has been seen high.
   logic        tog_done_r, tog_done_nxt; // Pulse already acted upon.
   logic        strap_r, strap_nxt;       // Strap captured one cycle after reset release.
   logic        fs_r, fs_nxt;             // Factory start flag.
   logic        fmt_r, fmt_nxt;           // Current primary format.

   // The toggle counts only while held high, so glitches shorter than the
   // least width never change the state; acting once per pulse avoids
   // repeated toggles on a long pulse.
   always_comb begin
      state_nxt   = state_r;
      tog_cnt_nxt = tog_cnt_r;
      tog_done_nxt = tog_done_r;
      strap_nxt   = strap_r;
      fs_nxt      = fs_r | supplies_lost;
      fmt_nxt     = fmt_r;
      if (fmt_cmd_valid) begin
         fmt_nxt = fmt_cmd_binary;
      end
      if (!toggle_in) begin
         tog_cnt_nxt  = '0;
         tog_done_nxt = 1'b0;
      end else if (!tog_done_r) begin
         if (tog_cnt_r == 17'(TOGGLE_CYC - 1)) begin
            tog_done_nxt = 1'b1;
         end else begin
            tog_cnt_nxt = tog_cnt_r + 17'd1;
         end
      end
      case (state_r)
         RPS_BOOT: begin
            strap_nxt = boot_select;
            state_nxt = RPS_ON;
         end
         RPS_ON: begin
            if (toggle_in && !tog_done_r && tog_cnt_r == 17'(TOGGLE_CYC - 1)) begin
               state_nxt = RPS_HIBERNATE;
            end
         end
         RPS_HIBERNATE: begin
            if (toggle_in && !tog_done_r && tog_cnt_r == 17'(TOGGLE_CYC - 1)) begin
               state_nxt = RPS_ON;
            end
         end
         default: state_nxt = RPS_ON;
      endcase
   end

   // Registers the power state group.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_r    <= RPS_BOOT;
         tog_cnt_r  <= '0;
         tog_done_r <= 1'b0;
         strap_r    <= 1'b0;
         fs_r       <= 1'b0;
         fmt_r      <= FMT_NMEA;
      end else begin
         state_r    <= state_nxt;
         tog_cnt_r  <= tog_cnt_nxt;
         tog_done_r <= tog_done_nxt;
         strap_r    <= strap_nxt;
         fs_r       <= fs_nxt;
         fmt_r      <= fmt_nxt;
      end
   end

   // Timing pulse: a lag counter after each epoch, then a width counter.
   logic [6:0] lag_cnt_r, lag_cnt_nxt;   // Counts down the lag, zero after a completed lag, kept when one is cut off.
   logic       lag_run_r, lag_run_nxt;   // Lag in progress.
   logic [6:0] wid_cnt_r, wid_cnt_nxt;   // Cycles left of the high pulse.
   logic       on_now;                   // Device in the on state.

   assign on_now = (state_r == RPS_ON);

   // The lag is a fixed count; the epoch is only trusted with a 3D fix.
   always_comb begin
      lag_cnt_nxt = lag_cnt_r;
      lag_run_nxt = lag_run_r;
      wid_cnt_nxt = wid_cnt_r;
      if (wid_cnt_r != '0) begin
         wid_cnt_nxt = wid_cnt_r - 7'd1;
      end
      if (utc_epoch && fix_3d_valid && on_now) begin
         lag_run_nxt = 1'b1;
         lag_cnt_nxt = 7'(PULSE_LAG_CYC - 1);
      end else if (lag_run_r) begin
         if (lag_cnt_r == '0) begin
            lag_run_nxt = 1'b0;
            wid_cnt_nxt = 7'(PULSE_CYC);
         end else begin
            lag_cnt_nxt = lag_cnt_r - 7'd1;
         end
      end
      if (!on_now || !fix_3d_valid) begin
         lag_run_nxt = 1'b0;
         wid_cnt_nxt = '0;
      end
   end

   // Registers the timing pulse group.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         lag_cnt_r <= '0;
         lag_run_r <= 1'b0;
         wid_cnt_r <= '0;
      end else begin
         lag_cnt_r <= lag_cnt_nxt;
         lag_run_r <= lag_run_nxt;
         wid_cnt_r <= wid_cnt_nxt;
      end
   end

   // Output pins: every one is registered so the pins never glitch.
   // Serial outputs idle high when on and fall to a break level in hibernate.
   logic rail_nxt, p_out_nxt, s_out_nxt, p_in_nxt, s_in_nxt;

   always_comb begin
      rail_nxt  = on_now || state_r == RPS_BOOT;
      p_out_nxt = on_now ? primary_tx_data : 1'b0;
      s_out_nxt = (on_now && secondary_enable) ? secondary_tx_data : on_now;
      p_in_nxt  = on_now ? primary_serial_in : 1'b1;
      s_in_nxt  = (on_now && secondary_enable) ? secondary_serial_in : 1'b1;
      if (!on_now) begin
         p_out_nxt = 1'b0;
         s_out_nxt = 1'b0;
      end
   end

   // Registers the pin group.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         io_rail_out          <= RAIL_RESET;
         core_power_en        <= 1'b1;
         primary_serial_out   <= 1'b1;
         secondary_serial_out <= 1'b1;
         primary_rx_data      <= 1'b1;
         secondary_rx_data    <= 1'b1;
         second_timing_pulse  <= 1'b0;
         factory_start        <= 1'b0;
         boot_mode            <= 1'b0;
         format_binary        <= FMT_NMEA;
      end else begin
         io_rail_out          <= rail_nxt;
         core_power_en        <= rail_nxt;
         primary_serial_out   <= p_out_nxt;
         secondary_serial_out <= s_out_nxt;
         primary_rx_data      <= p_in_nxt;
         secondary_rx_data    <= s_in_nxt;
         second_timing_pulse  <= (wid_cnt_nxt != '0);
         factory_start        <= fs_nxt;
         boot_mode            <= strap_nxt;
         format_binary        <= fmt_nxt;
      end
   end

   // Checks on the sequencing.
   property p_rail_off;
      @(posedge ref_clk) disable iff (!rst_n)
      state_r == RPS_HIBERNATE |=> !io_rail_out;
   endproperty
   a_rail_off: assert property (p_rail_off) else $error("rail high in hibernate");

   property p_break;
      @(posedge ref_clk) disable iff (!rst_n)
      state_r == RPS_HIBERNATE |=> !primary_serial_out && !secondary_serial_out;
   endproperty
   a_break: assert property (p_break) else $error("serial not at break");

   property p_short_toggle;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(toggle_in) ##1 !toggle_in |=> $stable(state_r);
   endproperty
   a_short_toggle: assert property (p_short_toggle) else $error("short toggle acted");

   property p_toggle_flip;
      @(posedge ref_clk) disable iff (!rst_n)
      (toggle_in && !tog_done_r && tog_cnt_r == 17'(TOGGLE_CYC - 1) && state_r == RPS_ON)
      |=> state_r == RPS_HIBERNATE && tog_done_r;
   endproperty
   a_toggle_flip: assert property (p_toggle_flip) else $error("toggle missed");

   property p_low_stays;
      @(posedge ref_clk) disable iff (!rst_n)
      !toggle_in && state_r == RPS_ON |=> state_r == RPS_ON;
   endproperty
   a_low_stays: assert property (p_low_stays) else $error("left on state");

   property p_pulse_width;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(second_timing_pulse) && fix_3d_valid && on_now ##1 (fix_3d_valid && on_now)[*8]
      |-> second_timing_pulse;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("pulse cut short");

   property p_pulse_lag;
      @(posedge ref_clk) disable iff (!rst_n)
      utc_epoch && fix_3d_valid && on_now ##1 (fix_3d_valid && on_now && !utc_epoch)[*8]
      |-> !second_timing_pulse;
   endproperty
   a_pulse_lag: assert property (p_pulse_lag) else $error("pulse too early");

   property p_no_fix;
      @(posedge ref_clk) disable iff (!rst_n)
      !fix_3d_valid |=> !second_timing_pulse;
   endproperty
   a_no_fix: assert property (p_no_fix) else $error("pulse without fix");

   property p_fs;
      @(posedge ref_clk) disable iff (!rst_n)
      supplies_lost |=> factory_start [*2];
   endproperty
   a_fs: assert property (p_fs) else $error("factory start not held");

   property p_sec_quiet;
      @(posedge ref_clk) disable iff (!rst_n)
      !secondary_enable && on_now |=> secondary_serial_out;
   endproperty
   a_sec_quiet: assert property (p_sec_quiet) else $error("secondary port sent");

   c_hib: cover property (@(posedge ref_clk) state_r == RPS_ON ##1 state_r == RPS_HIBERNATE);
   c_wake: cover property (@(posedge ref_clk) state_r == RPS_HIBERNATE ##1 state_r == RPS_ON);
   c_pulse: cover property (@(posedge ref_clk) $rose(second_timing_pulse));
   c_fmt: cover property (@(posedge ref_clk) $rose(format_binary));

endmodule : rps_power_seq

// ---- src/rps_pkg.sv ----
// Shared constants for the receiver power and host pin sequencer.
// Assumes a single 100 MHz clock; all times are converted to cycle counts here.
package rps_pkg;
   // Clock period in nanoseconds.
   localparam int CLK_PERIOD_NS   = 10;
   // Least width of a toggle pulse, in microseconds.
   localparam int TOGGLE_MIN_US   = 1000;
   localparam int TOGGLE_CYC      = (TOGGLE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Timing pulse width in nanoseconds, rounded up to whole cycles.
   localparam int PULSE_WIDTH_NS  = 1000;
   localparam int PULSE_CYC       = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Lag of the timing pulse behind the epoch, nominal.
   localparam int PULSE_LAG_NS    = 450;
   localparam int PULSE_LAG_CYC   = PULSE_LAG_NS / CLK_PERIOD_NS;
   // One second in cycles.
   localparam int SECOND_NS       = 1000000000;
   localparam int SECOND_CYC      = SECOND_NS / CLK_PERIOD_NS;
   // Default primary port baud rate and bit period in cycles.
   localparam int DEFAULT_BAUD    = 4800;
   localparam int BAUD_CYC        = 100000000 / DEFAULT_BAUD;
   // Reset values of the power state outputs.
   localparam logic RAIL_RESET    = 1'b1;
   localparam logic FMT_NMEA      = 1'b0;
   // Power states.
   typedef enum logic [1:0] {RPS_BOOT, RPS_ON, RPS_HIBERNATE} rps_state_e;
endpackage : rps_pkg

// ---- test/rps_host_model.sv ----
// Host controller model: drives the power toggle and both serial inputs.
// Assumes ref_clk from the bench and the sensed rail from the device.
`timescale 1ns/100ps
module rps_host_model (
   input  wire logic        ref_clk,             // Bench clock.
   input  wire logic        io_rail_out,         // Sensed power state.
   input  wire logic        pulse_go,            // Start a toggle pulse.
   input  wire logic [16:0] pulse_len,           // Pulse length in cycles.
   input  wire logic        host_tx,             // Host data for the primary line.
   input  wire logic        host_tx2,            // Host data for the secondary line.
   output logic             toggle_in,           // Toggle pin.
   output logic             primary_serial_in,   // Primary line to the device.
   output logic             secondary_serial_in  // Secondary line to the device.
);
   logic [16:0] left_r = 17'h0; // Cycles of pulse still to drive.
   // A pulse is held high for its whole length, then released low.
   // Spacing between pulses is left to the bench. A full second would be
   // a hundred million cycles, so the bench spaces pulses by only a few
   // cycles, or one timing pulse test, instead; the device does not police the spacing.
   always @(posedge ref_clk) begin
      if (pulse_go) begin
         left_r <= pulse_len;
      end else if (left_r != 17'h0) begin
         left_r <= left_r - 17'h1;
      end
   end
   assign toggle_in = (left_r != 17'h0);
   // Lines are pulled low, never driven high, while the device sleeps.
   assign primary_serial_in   = io_rail_out & host_tx;
   assign secondary_serial_in = io_rail_out & host_tx2;
endmodule : rps_host_model

// ---- test/testbench.sv ----
// Self-checking bench for the power sequencer: toggle, hibernate, serial
// pins, timing pulse, strap and supply loss. Assumes the host model is built.
`timescale 1ns/100ps
module testbench;
   import rps_pkg::*;
   logic ref_clk = 1'b0;      // Bench clock.
   logic rst_n = 1'b0;        // Reset, active low.
   logic supplies_lost = 1'b0, boot_select = 1'b0, fix_3d_valid = 1'b0;
   logic utc_epoch = 1'b0, primary_tx_data = 1'b1, secondary_tx_data = 1'b1;
   logic secondary_enable = 1'b0, fmt_cmd_valid = 1'b0, fmt_cmd_binary = 1'b0;
   logic pulse_go = 1'b0, host_tx = 1'b1, host_tx2 = 1'b1; // Host controls.
   logic [16:0] pulse_len = 17'h0;  // Requested toggle length.
   logic toggle_in, primary_serial_in, secondary_serial_in; // Host pins.
   logic io_rail_out, core_power_en, primary_serial_out, secondary_serial_out;
   logic primary_rx_data, secondary_rx_data, second_timing_pulse;
   logic factory_start, boot_mode, format_binary;
   int err_total = 0;   // Mismatches seen.
   int num_checks = 0;  // Comparisons made.

   // Clock inverts every half period.
   always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

   rps_host_model rps_host_model_inst (.ref_clk(ref_clk), .io_rail_out(io_rail_out),
      .pulse_go(pulse_go), .pulse_len(pulse_len), .host_tx(host_tx), .host_tx2(host_tx2),
      .toggle_in(toggle_in), .primary_serial_in(primary_serial_in),
      .secondary_serial_in(secondary_serial_in));

   rps_power_seq rps_power_seq_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .supplies_lost(supplies_lost), .toggle_in(toggle_in), .boot_select(boot_select),
      .fix_3d_valid(fix_3d_valid), .utc_epoch(utc_epoch),
      .primary_tx_data(primary_tx_data), .secondary_tx_data(secondary_tx_data),
      .secondary_enable(secondary_enable), .primary_serial_in(primary_serial_in),
      .secondary_serial_in(secondary_serial_in), .fmt_cmd_valid(fmt_cmd_valid),
      .fmt_cmd_binary(fmt_cmd_binary), .io_rail_out(io_rail_out),
      .core_power_en(core_power_en), .primary_serial_out(primary_serial_out),
      .secondary_serial_out(secondary_serial_out), .primary_rx_data(primary_rx_data),
      .secondary_rx_data(secondary_rx_data), .second_timing_pulse(second_timing_pulse),
      .factory_start(factory_start), .boot_mode(boot_mode), .format_binary(format_binary));

   // Compares one value; four-state equality so an unknown never matches.
   task automatic check(input logic seen, input logic exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   // Waits n edges, then lets that edge's updates settle.
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   // Reset with a chosen strap; the strap is held across release.
   task automatic t_reset(input logic strap);
      @(posedge ref_clk);
      rst_n       <= 1'b0;
      boot_select <= strap;
      tick(4);
      check(io_rail_out, 1'b1);
      check(format_binary, FMT_NMEA);
      @(posedge ref_clk);
      rst_n <= 1'b1;
      tick(3);
      check(boot_mode, strap);
      check(factory_start, 1'b0);
      $display("reset test done");
   endtask : t_reset

   // Serial pins: idle, data, silent secondary, then enabled, format change.
   task automatic t_serial;
      @(posedge ref_clk);
      primary_tx_data   <= 1'b0;
      secondary_tx_data <= 1'b0;
      host_tx2          <= 1'b0;
      host_tx           <= 1'b0;
      tick(2);
      check(primary_serial_out, 1'b0);
      check(primary_rx_data, 1'b0);
      check(secondary_serial_out, 1'b1);
      check(secondary_rx_data, 1'b1);
      @(posedge ref_clk);
      primary_tx_data  <= 1'b1;
      host_tx          <= 1'b1;
      secondary_enable <= 1'b1;
      fmt_cmd_valid    <= 1'b1;
      fmt_cmd_binary   <= 1'b1;
      @(posedge ref_clk);
      fmt_cmd_valid <= 1'b0;
      tick(2);
      check(primary_serial_out, 1'b1);
      check(primary_rx_data, 1'b1);
      check(secondary_serial_out, 1'b0);
      check(secondary_rx_data, 1'b0);
      check(format_binary, 1'b1);
      @(posedge ref_clk);
      secondary_enable  <= 1'b0;
      secondary_tx_data <= 1'b1;
      host_tx2          <= 1'b1;
      $display("serial test done");
   endtask : t_serial

   // One epoch; the pulse must rise 46 edges later and last 100 cycles.
   task automatic t_pulse(input logic fix, input logic on);
      @(posedge ref_clk);
      fix_3d_valid <= fix;
      utc_epoch    <= 1'b1;
      @(posedge ref_clk);
      utc_epoch <= 1'b0;
      tick(44);
      check(second_timing_pulse, 1'b0);
      tick(1);
      check(second_timing_pulse, fix & on);
      tick(99);
      check(second_timing_pulse, fix & on);
      tick(1);
      check(second_timing_pulse, 1'b0);
      $display("timing pulse test done");
   endtask : t_pulse

   // One toggle pulse of len cycles; the rail and serial pins must show rail, primary_rx_data high.
   // The block has no duty-cycled mode, so every pulse starts from full
   // power or hibernate.
   task automatic t_toggle(input int len, input logic rail);
      @(posedge ref_clk);
      pulse_go  <= 1'b1;
      pulse_len <= 17'(len);
      @(posedge ref_clk);
      pulse_go <= 1'b0;
      tick(len + 2);
      check(io_rail_out, rail);
      check(core_power_en, rail);
      check(primary_serial_out, rail);
      check(secondary_serial_out, rail);
      check(primary_serial_in, rail);
      check(primary_rx_data, 1'b1);
      $display("toggle test done");
   endtask : t_toggle

   // Supply loss is raised last, so no toggle follows it.
   task automatic t_supply;
      @(posedge ref_clk);
      supplies_lost <= 1'b1;
      @(posedge ref_clk);
      supplies_lost <= 1'b0;
      tick(3);
      check(factory_start, 1'b1);
      $display("supply test done");
   endtask : t_supply

   // Main sequence.
   initial begin
      t_reset(1'b0);
      t_serial();
      t_pulse(1'b1, 1'b1);
      t_pulse(1'b0, 1'b1);
      t_toggle(1, 1'b1);
      t_toggle(99999, 1'b1);
      t_toggle(100500, 1'b0);
      t_pulse(1'b1, 1'b0);
      t_toggle(100000, 1'b1);
      t_reset(1'b1);
      t_supply();
      stop_test();
   end

   // Watchdog: the tests need about 301000 cycles.
   initial begin
      #3500000;
      err_total++;
      stop_test();
   end
endmodule : testbench
